// ===== fan_pwm_pkg.sv
// shared constants for the fan pwm prescaler and hysteresis block
package fan_pwm_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_FAN1_PWM_PRESCALER = 8'h71;
  localparam logic [7:0] IDX_FAN2_PWM_PRESCALER = 8'h72;
  localparam logic [7:0] IDX_FAN3_PWM_PRESCALER = 8'h73;
  localparam logic [7:0] IDX_TEMP1_HYSTERESIS = 8'h74;
  localparam logic [7:0] IDX_TEMP2_HYSTERESIS = 8'h75;
  localparam logic [7:0] IDX_TEMP3_HYSTERESIS = 8'h76;
  localparam logic [7:0] IDX_FAN_STARTUP_DUTY = 8'h77;
  localparam int ADDR_LSB = 2;
  localparam int IDX_W = 8;
  // ---------------------------------------------------------------
  // reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [7:0] PRESCALER_RST = 8'h84;
  localparam logic [7:0] HYST_RST = 8'h53;
  localparam logic [7:0] STARTUP_RST = 8'h30;
  localparam logic [7:0] HYST_MASK = 8'h77;
  localparam int REF_SEL_BIT = 7;
  localparam int CRIT_LSB = 4;
  localparam int OPER_LSB = 0;
  localparam int HYST_W = 3;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 200_000_000;
  localparam int REF_FAST_HZ = 125_000;
  localparam int REF_SLOW_HZ = 1_000;
  localparam int FAST_TICK_CYCLES = CLK_HZ / REF_FAST_HZ;
  localparam int SLOW_TICK_CYCLES = CLK_HZ / REF_SLOW_HZ;
  localparam int RATIO_W = 11;
  localparam int DUTY_W = 8;
endpackage

// ===== fan_pwm_channel.sv
// one fan pwm output: period divider, duty compare, glitch-free reload
`timescale 1ns/1ps
`default_nettype none
module fan_pwm_channel
  import fan_pwm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic fast_tick_i,
  input wire logic slow_tick_i,
  input wire logic [7:0] prescaler_i,
  input wire logic [DUTY_W-1:0] duty_i,
  output logic pwm_o,
  output logic period_start_o
);
  // ---------------------------------------------------------------
  // ratio decode
  // ---------------------------------------------------------------
  wire logic use_fast = prescaler_i[REF_SEL_BIT];
  wire logic [RATIO_W-1:0] fast_ratio = {4'h0, prescaler_i[6:0]} + 11'h001;
  logic [RATIO_W-1:0] slow_ratio;
  always_comb
  begin
    case (prescaler_i[3:0])
      4'h8: slow_ratio = 11'h00c;
      4'h9: slow_ratio = 11'h010;
      4'ha: slow_ratio = 11'h020;
      4'hb: slow_ratio = 11'h040;
      4'hc: slow_ratio = 11'h080;
      4'hd: slow_ratio = 11'h100;
      4'he: slow_ratio = 11'h200;
      4'hf: slow_ratio = 11'h400;
      default: slow_ratio = {7'h00, prescaler_i[3:0]} + 11'h001;
    endcase
  end
  // reserved fast codes are not trapped; ratio still follows divisor+1
  wire logic [RATIO_W-1:0] new_ratio = use_fast ? fast_ratio : slow_ratio;
  // ---------------------------------------------------------------
  // period counter, one duty step per reference tick group
  // ---------------------------------------------------------------
  logic sel_q;
  logic [RATIO_W-1:0] ratio_q;
  logic [RATIO_W-1:0] cnt_q;
  logic [DUTY_W-1:0] phase_q;
  logic [DUTY_W-1:0] duty_q;
  logic pwm_q;
  wire logic tick = sel_q ? fast_tick_i : slow_tick_i;
  wire logic step = tick && (cnt_q == ratio_q - 11'h001);
  wire logic wrap = step && (phase_q == 8'hff);
  assign pwm_o = pwm_q;
  assign period_start_o = wrap;
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sel_q <= 1'b1;
      ratio_q <= 11'h005;
      cnt_q <= '0;
      phase_q <= '0;
      duty_q <= '0;
      pwm_q <= 1'b0;
    end
    else
    begin
      if (tick)
        cnt_q <= step ? '0 : cnt_q + 11'h001;
      if (step)
        phase_q <= phase_q + 8'h01;
      // new setting only at period end, never mid-cycle
      if (wrap)
      begin
        sel_q <= use_fast;
        ratio_q <= new_ratio;
        duty_q <= duty_i;
      end
      pwm_q <= (phase_q < duty_q);
    end
  end
endmodule // fan_pwm_channel
`default_nettype wire

// ===== fan_pwm_prescale_hysteresis.sv
// register file and three pwm outputs with reference tick generation
// Overview of operation
// - each fan divides its selected reference by its divisor for pwm frequency.
// - select bit one gives 125 kHz over divisor plus one.
// - fast mode valid codes 0..7 and 15,31,63,127; others reserved for software.
// - select bit zero uses divisor 3:0 mapped table over 1000 Hz.
// - three read/write prescaler registers, reset 84h, 25 kHz.
// - hysteresis registers: critical in 6:4, operating in 2:0, reset 53h.
// - each channel's hysteresis is applied to its own comparisons.
// - shared start-up duty register, reset 30h, used when spinning up.
`timescale 1ns/1ps
`default_nettype none
module fan_pwm_prescale_hysteresis
  import fan_pwm_pkg::*;
#(
  parameter int NUM_FANS = 3,
  parameter int SLOW_TICK_CYCLES_P = SLOW_TICK_CYCLES
)
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [NUM_FANS-1:0] fan_starting_i,
  input wire logic [NUM_FANS*DUTY_W-1:0] fan_duty_i,
  output logic [NUM_FANS-1:0] fan_pwm_o,
  output logic [NUM_FANS-1:0] fan_period_start_o,
  output logic [NUM_FANS*HYST_W-1:0] operating_hyst_o,
  output logic [NUM_FANS*HYST_W-1:0] critical_hyst_o,
  output logic [DUTY_W-1:0] fan_spinup_level_o
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end
  // ---------------------------------------------------------------
  // reference ticks
  // ---------------------------------------------------------------
  // duty-step ticks, 256 per reference period, so a ratio n gives ref/n
  // fractional accumulators: any 256 ticks span exactly one reference period
  // limitation: a reference period below 256 clocks cannot be reached
  logic [31:0] fast_acc_q;
  logic [31:0] slow_acc_q;
  wire logic [31:0] step_inc = 32'(1 << DUTY_W);
  wire logic [31:0] fast_sum = fast_acc_q + step_inc;
  wire logic [31:0] slow_sum = slow_acc_q + step_inc;
  wire logic fast_tick = (fast_sum >= 32'(FAST_TICK_CYCLES));
  wire logic slow_tick = (slow_sum >= 32'(SLOW_TICK_CYCLES_P));
  always_ff @(posedge mclk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      fast_acc_q <= '0;
      slow_acc_q <= '0;
    end
    else
    begin
      fast_acc_q <= fast_tick ? fast_sum - 32'(FAST_TICK_CYCLES) : fast_sum;
      slow_acc_q <= slow_tick ? slow_sum - 32'(SLOW_TICK_CYCLES_P) : slow_sum;
    end
  end
  // ---------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ---------------------------------------------------------------
  logic wr_pend_q;
  logic rd_pend_q;
  logic [IDX_W-1:0] idx_q;
  logic [7:0] presc_q [NUM_FANS];
  logic [7:0] hyst_q [NUM_FANS];
  logic [7:0] startup_q;
  wire logic addr_ok = hsel_i && hready_i && htrans_i[1];
  wire logic [IDX_W-1:0] addr_idx = haddr_i[ADDR_LSB +: IDX_W];
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  always_ff @(posedge mclk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q <= '0;
    end
    else
    begin
      wr_pend_q <= addr_ok && hwrite_i;
      rd_pend_q <= addr_ok && !hwrite_i;
      if (addr_ok)
        idx_q <= addr_idx;
    end
  end
  // ---------------------------------------------------------------
  // registers per channel
  // ---------------------------------------------------------------
  logic [7:0] rd_word [NUM_FANS*2];
  genvar g;
  generate
    for (g = 0; g < NUM_FANS; g++)
    begin : g_ch
      wire logic presc_hit = (idx_q == IDX_FAN1_PWM_PRESCALER + 8'(g));
      wire logic hyst_hit = (idx_q == IDX_TEMP1_HYSTERESIS + 8'(g));
      always_ff @(posedge mclk_i or negedge rst_n_q)
      begin
        if (!rst_n_q)
        begin
          presc_q[g] <= PRESCALER_RST;
          hyst_q[g] <= HYST_RST;
        end
        else
        begin
          if (wr_pend_q && presc_hit)
            presc_q[g] <= hwdata_i[7:0];
          if (wr_pend_q && hyst_hit)
            hyst_q[g] <= hwdata_i[7:0] & HYST_MASK;
        end
      end
      assign rd_word[g] = presc_hit ? presc_q[g] : 8'h00;
      assign rd_word[NUM_FANS+g] = hyst_hit ? hyst_q[g] : 8'h00;
      // per-channel hysteresis to that channel's comparators
      assign operating_hyst_o[g*HYST_W +: HYST_W] = hyst_q[g][OPER_LSB +: HYST_W];
      assign critical_hyst_o[g*HYST_W +: HYST_W] = hyst_q[g][CRIT_LSB +: HYST_W];
      wire logic [DUTY_W-1:0] duty_sel = fan_starting_i[g] ? startup_q
                                       : fan_duty_i[g*DUTY_W +: DUTY_W];
      fan_pwm_channel u_ch (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_q),
        .fast_tick_i(fast_tick),
        .slow_tick_i(slow_tick),
        .prescaler_i(presc_q[g]),
        .duty_i(duty_sel),
        .pwm_o(fan_pwm_o[g]),
        .period_start_o(fan_period_start_o[g])
      );
    end
  endgenerate
  always_ff @(posedge mclk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      startup_q <= STARTUP_RST;
    else if (wr_pend_q && idx_q == IDX_FAN_STARTUP_DUTY)
      startup_q <= hwdata_i[7:0];
  end
  assign fan_spinup_level_o = startup_q;
  // ---------------------------------------------------------------
  // read mux, unmapped reads as zero
  // ---------------------------------------------------------------
  logic [7:0] rd_or;
  always_comb
  begin
    rd_or = (idx_q == IDX_FAN_STARTUP_DUTY) ? startup_q : 8'h00;
    for (int i = 0; i < NUM_FANS*2; i++)
      rd_or = rd_or | rd_word[i];
  end
  assign hrdata_o = rd_pend_q ? {24'h000000, rd_or} : 32'h0000_0000;
endmodule // fan_pwm_prescale_hysteresis
`default_nettype wire

// ===== fan_pwm_prescale_hysteresis_sva.sv
// concurrent checks on the fan pwm register block ports
`timescale 1ns/1ps
`default_nettype none
module fan_pwm_sva
  import fan_pwm_pkg::*;
#(parameter int NUM_FANS = 3)
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [NUM_FANS*HYST_W-1:0] operating_hyst_o,
  input wire logic [NUM_FANS*HYST_W-1:0] critical_hyst_o,
  input wire logic [DUTY_W-1:0] fan_spinup_level_o
);
  // ---------------------------------------------------------------
  // data phase tracking
  // ---------------------------------------------------------------
  logic wr_q;
  logic rd_q;
  logic [7:0] idx_q;
  wire logic take = hsel_i & hready_i & htrans_i[1] & (haddr_i[31:10] == 22'h0);
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else
    begin
      wr_q <= take & hwrite_i;
      rd_q <= take & ~hwrite_i;
    end
  end
  // index needs no reset: only looked at while a phase flag is set
  always_ff @(posedge mclk_i)
    idx_q <= haddr_i[9:2];
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_wr(logic [7:0] ix);
    wr_q && idx_q == ix;
  endsequence
  sequence s_rd(logic [7:0] ix);
    rd_q && idx_q == ix;
  endsequence
  a_spinup_write: assert property (s_wr(IDX_FAN_STARTUP_DUTY) |=>
    fan_spinup_level_o == $past(hwdata_i[7:0])) else $error("spin-up level missed write");
  a_spinup_hold: assert property (!(wr_q && idx_q == IDX_FAN_STARTUP_DUTY) |=>
    $stable(fan_spinup_level_o)) else $error("spin-up level changed unasked");
  a_rdata_spin: assert property (s_rd(IDX_FAN_STARTUP_DUTY) |->
    hrdata_o == {24'h0, fan_spinup_level_o}) else $error("spin-up read mismatch");
  a_rdata_idle: assert property (!rd_q |-> hrdata_o == 32'h0)
    else $error("read data outside read phase");
  a_okay_ready: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready okay");
  a_hyst_rsv: assert property (rd_q && idx_q inside {[8'h74:8'h76]} |->
    (hrdata_o & ~32'h77) == 32'h0) else $error("hysteresis reserved bits set");
  for (genvar n = 0; n < 3; n++)
  begin : g_hyst
    a_hyst_write: assert property (s_wr(8'(IDX_TEMP1_HYSTERESIS + n)) |=>
      operating_hyst_o[n*3 +: 3] == $past(hwdata_i[2:0]) &&
      critical_hyst_o[n*3 +: 3] == $past(hwdata_i[6:4])) else $error("hysteresis write lost");
    a_hyst_read: assert property (s_rd(8'(IDX_TEMP1_HYSTERESIS + n)) |->
      hrdata_o[2:0] == operating_hyst_o[n*3 +: 3] &&
      hrdata_o[6:4] == critical_hyst_o[n*3 +: 3]) else $error("hysteresis output mismatch");
  end
endmodule // fan_pwm_sva
bind fan_pwm_prescale_hysteresis fan_pwm_sva #(.NUM_FANS(NUM_FANS)) u_sva (.mclk_i(mclk_i),
  .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hready_i(hready_i), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .operating_hyst_o(operating_hyst_o),
  .critical_hyst_o(critical_hyst_o), .fan_spinup_level_o(fan_spinup_level_o));
`default_nettype wire

// ===== fan_pwm_fan_model.sv
// behavioural fans that need the start-up level until they have turned once
`timescale 1ns/1ps
`default_nettype none
module fan_pwm_fan_model
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [2:0] pwm_i,
  input wire logic [2:0] period_start_i,
  output logic [2:0] starting_o
);
  logic [2:0] seen_q;
  // a fan that saw no drive pulse in a period is still stalled
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      seen_q <= 3'b000;
      starting_o <= 3'b111;
    end
    else
    begin
      seen_q <= (seen_q | pwm_i) & ~period_start_i;
      starting_o <= starting_o & ~(period_start_i & seen_q);
    end
  end
endmodule // fan_pwm_fan_model
`default_nettype wire

// ===== fan_pwm_prescale_hysteresis_bench.sv
// self-checking bench for the fan pwm register block
`timescale 1ns/1ps
`default_nettype none
module fan_pwm_prescale_hysteresis_bench;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic [1:0] htrans_i = 2'b00;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] haddr_i = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic [31:0] rd;
  logic hreadyout_o;
  logic hresp_o;
  logic [2:0] starting;
  logic [2:0] pwm;
  logic [2:0] pstart;
  logic [8:0] oper;
  logic [8:0] crit;
  logic [7:0] spin;
  int errors = 0;
  int check_count = 0;
  logic [7:0] ix [7] = '{8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77};
  logic [7:0] rv [7] = '{8'h84, 8'h84, 8'h84, 8'h53, 8'h53, 8'h53, 8'h30};
  logic [7:0] wv [7] = '{8'h8f, 8'h0f, 8'hff, 8'hff, 8'h2c, 8'h15, 8'hc5};
  logic [7:0] ev [7] = '{8'h8f, 8'h0f, 8'hff, 8'h77, 8'h24, 8'h15, 8'hc5};
  always #2.5 mclk_i = ~mclk_i;
  // slow reference period cut to 512 clocks so slow-mode periods fit the run
  fan_pwm_prescale_hysteresis #(.SLOW_TICK_CYCLES_P(512)) DUT (.mclk_i(mclk_i),
    .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .fan_starting_i(starting), .fan_duty_i(24'h40_80_c0), .fan_pwm_o(pwm),
    .fan_period_start_o(pstart), .operating_hyst_o(oper), .critical_hyst_o(crit),
    .fan_spinup_level_o(spin));
  fan_pwm_fan_model FANS (.mclk_i(mclk_i), .nrst_i(nrst_i), .pwm_i(pwm),
    .period_start_i(pstart), .starting_o(starting));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // entered just after an edge; waits on ready, never on a fixed count
  task xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel_i <= 1'b1;
    haddr_i <= {22'h0, idx, 2'b00};
    hwrite_i <= wr;
    htrans_i <= 2'b10;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask
  // one full period of fan c, from one period pulse to the next
  task automatic measure(input int c, output int len, output int high);
    len = 0;
    high = 0;
    do @(posedge mclk_i); while (pstart[c] !== 1'b1);
    do
    begin
      @(posedge mclk_i);
      len++;
      if (pwm[c] === 1'b1)
        high++;
    end
    while (pstart[c] !== 1'b1);
  endtask
  // second period runs at start-up duty, fourth at the normal duty
  task automatic run_fan(input int c, input int len_x, input int hi_start, input int hi_run);
    int len;
    int high;
    measure(c, len, high);
    chk("pwm period", len, len_x);
    chk("start-up high time", high, hi_start);
    measure(c, len, high);
    chk("pwm period after reload", len, len_x);
    chk("running high time", high, hi_run);
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    for (int i = 0; i < 7; i++)
    begin
      xfer(1'b0, ix[i], 32'h0);
      chk("reset value", rd, {24'h0, rv[i]});
    end
    chk("operating hysteresis", {23'h0, oper}, 32'h0db);
    chk("critical hysteresis", {23'h0, crit}, 32'h16d);
    // upper data bits set on purpose: only the low byte may land
    for (int i = 0; i < 7; i++)
      xfer(1'b1, ix[i], {24'hffffff, wv[i]});
    xfer(1'b1, 8'h78, 32'h5a);
    xfer(1'b0, 8'h78, 32'h0);
    chk("unmapped read", rd, 32'h0);
    for (int i = 0; i < 7; i++)
    begin
      xfer(1'b0, ix[i], 32'h0);
      chk("readback", rd, {24'h0, ev[i]});
    end
    chk("operating hysteresis", {23'h0, oper}, 32'h167);
    chk("critical hysteresis", {23'h0, crit}, 32'h057);
    chk("spin-up level", {24'h0, spin}, 32'hc5);
    nrst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    xfer(1'b0, 8'h73, 32'h0);
    chk("value after second reset", rd, 32'h84);
    // fan 1 fast ratio 2, fan 2 slow code 8 with ignored upper bits, fan 3 default
    xfer(1'b1, 8'h71, 32'h81);
    xfer(1'b1, 8'h72, 32'h78);
    fork
      run_fan(0, 3200, 600, 2400);
      run_fan(1, 6144, 1152, 3072);
      run_fan(2, 8000, 1500, 2000);
    join
    chk("fans spun up", {29'h0, starting}, 32'h0);
    end_of_test();
  end
  // the pwm scenario needs about 32000 cycles; this leaves margin
  initial
  begin
    repeat (40000) @(posedge mclk_i);
    errors++;
    end_of_test();
  end
endmodule // fan_pwm_prescale_hysteresis_bench
`default_nettype wire
